// ### hw/fmsp_top.sv
// Four-mode serial port: control and buffer registers, mode 0 shifter, async tx and rx.
// Assumes a single-cycle register port from the core, timer overflow pulses on the same
// clock, and pins that are resolved outside from the output and enable signals.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

// Behaviour
// - Async transmit and receive run independently
// - Received byte held while next shifts in
// - Buffer write feeds transmit, read gives receive
// - Every buffer write starts a transmission
// - Two mode bits pick one of four modes
// - Mode 1 check drops frames with low stop
// - Modes 2/3 check drops frames with low ninth
// - Check bit ignored in mode 0
// - Receive enable gates async reception
// - Mode 0 enable clear-then-set receives one byte
// - Ninth transmit bit sent in modes 2/3
// - Ninth receive bit captures ninth or stop; the code leaves it alone in mode 1 with the check on
// - Transmit done set after last bit
// - Receive done set after frame, if accepted
// - Done flags cleared only by software
// - Done flag raises interrupt when enabled
// - Mode 0 clock is oscillator over 12 or 6
// - Modes 1/3 rate from timer overflows
// - Mode 2 rate is oscillator over divisor
// - Baud double picks the smaller divisor
// - Mode 0 data on rx pin, clock on tx
// - Mode 1 frame: start, eight data, stop
// - Async receive starts on falling edge
// - Mode 2 frame carries ninth bit, eleven total
module fmsp_top (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       baud_double,
   input  wire logic       twelve_clock_operation,
   input  wire logic       timer1_overflow,
   input  wire logic       timer2_overflow,
   input  wire logic       rx_use_timer2,
   input  wire logic       tx_use_timer2,
   input  wire logic       serial_irq_enable,
   input  wire logic       rxd_in,
   output logic            rxd_out,
   output logic            rxd_oe_n,
   output logic            txd_out,
   output logic            serial_irq
);
   import fmsp_pkg::*;

   typedef enum logic [1:0] {ARX_IDLE, ARX_START, ARX_BITS} fmsp_arx_t;

   logic [7:0] ctl_r;
   logic [7:0] rx_buf_r;
   logic [7:0] rdata_r;
   logic       irq_r;
   logic       ren_prev_r;
   logic [2:0] rxd_sync_r;
   logic       rxd_f_r;
   logic       rxd_prev_r;
   logic [2:0] pre_r;
   logic       t1_half_r;
   logic [3:0] m0_cnt_r;
   logic [2:0] m0_bit_r;
   logic [7:0] m0_sh_r;
   logic       m0_act_r;
   logic       m0_rx_r;
   logic       atx_act_r;
   logic [3:0] atx_sub_r;
   logic [3:0] atx_bit_r;
   logic [10:0] atx_sh_r;
   fmsp_arx_t  arx_st_r;
   logic [3:0] arx_sub_r;
   logic [3:0] arx_bit_r;
   logic [7:0] arx_sh_r;
   logic       txd_r;
   logic       rxd_out_r;
   logic       rxd_oe_n_r;

   logic [1:0] mode;
   logic       ctl_wr;
   logic       buf_wr;
   logic [3:0] m0_div;
   logic [3:0] m0_samp;
   logic [2:0] pre_div;
   logic       m2_tick;
   logic       t1_tick;
   logic       rx_tick;
   logic       tx_tick;
   logic       m0_end;
   logic       atx_end;
   logic       arx_samp;
   logic       arx_last;
   logic       frame_bit;
   logic       rx_accept;
   logic       tx_done_set;
   logic       rx_done_set;
   logic       rb8_load;
   logic       m0_rx_start;

   assign mode   = {ctl_r[BIT_MODE_HIGH], ctl_r[BIT_MODE_LOW]};
   assign ctl_wr = reg_wr && (reg_addr == ADDR_SERIAL_CONTROL);
   assign buf_wr = reg_wr && (reg_addr == ADDR_SERIAL_BUFFER);

   // ----------------------------------------------------------------------
   // Rate generation
   // ----------------------------------------------------------------------
   assign m0_div  = twelve_clock_operation ? M0_DIV_TWELVE : M0_DIV_SIX;
   assign m0_samp = twelve_clock_operation ? M0_SAMPLE_TW : M0_SAMPLE_SIX;
   always_comb begin
      if (twelve_clock_operation) begin
         pre_div = baud_double ? M2_PRE_32 : M2_PRE_64;
      end else begin
         pre_div = baud_double ? M2_PRE_16 : M2_PRE_32;
      end
   end
   assign m2_tick = (pre_r == pre_div - 3'h1);
   // Timer 1 gives the bit over 32 overflows unless doubled to 16.
   assign t1_tick = timer1_overflow && (baud_double || t1_half_r);
   assign rx_tick = (mode == MODE_FIXED11) ? m2_tick :
                    (rx_use_timer2 ? timer2_overflow : t1_tick);
   assign tx_tick = (mode == MODE_FIXED11) ? m2_tick :
                    (tx_use_timer2 ? timer2_overflow : t1_tick);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pre_r <= 3'h0;
      end else if (m2_tick || pre_r >= pre_div) begin
         pre_r <= 3'h0;
      end else begin
         pre_r <= pre_r + 3'h1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         t1_half_r <= 1'b0;
      end else if (timer1_overflow) begin
         t1_half_r <= ~t1_half_r;
      end
   end

   // ----------------------------------------------------------------------
   // Receive pin synchroniser
   // ----------------------------------------------------------------------
   // The filtered level moves only when the second and third stages agree.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxd_sync_r <= 3'h7;
         rxd_f_r    <= 1'b1;
         rxd_prev_r <= 1'b1;
      end else begin
         rxd_sync_r <= {rxd_sync_r[1:0], rxd_in};
         if (rxd_sync_r[1] == rxd_sync_r[2]) begin
            rxd_f_r <= rxd_sync_r[2];
         end
         rxd_prev_r <= rxd_f_r;
      end
   end

   // ----------------------------------------------------------------------
   // Mode 0 synchronous shifter
   // ----------------------------------------------------------------------
   // Mode 0 is half duplex: one shifter serves both directions.
   assign m0_rx_start = (mode == MODE_SYNC8) && !m0_act_r && !ren_prev_r
                        && ctl_r[BIT_RX_ENABLE] && !ctl_r[BIT_RX_DONE];
   assign m0_end = m0_act_r && (m0_cnt_r == m0_div - 4'h1) && (m0_bit_r == M0_LAST_BIT);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ren_prev_r <= 1'b0;
      end else begin
         ren_prev_r <= ctl_r[BIT_RX_ENABLE];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         m0_act_r <= 1'b0;
         m0_rx_r  <= 1'b0;
         m0_cnt_r <= 4'h0;
         m0_bit_r <= 3'h0;
         m0_sh_r  <= 8'h00;
      end else if (buf_wr && mode == MODE_SYNC8) begin
         m0_act_r <= 1'b1;
         m0_rx_r  <= 1'b0;
         m0_cnt_r <= 4'h0;
         m0_bit_r <= 3'h0;
         m0_sh_r  <= reg_wdata;
      end else if (m0_rx_start) begin
         m0_act_r <= 1'b1;
         m0_rx_r  <= 1'b1;
         m0_cnt_r <= 4'h0;
         m0_bit_r <= 3'h0;
      end else if (m0_act_r) begin
         if (m0_rx_r && m0_cnt_r == m0_samp) begin
            m0_sh_r <= {rxd_f_r, m0_sh_r[7:1]};
         end
         if (m0_cnt_r == m0_div - 4'h1) begin
            m0_cnt_r <= 4'h0;
            m0_bit_r <= m0_bit_r + 3'h1;
            if (!m0_rx_r) begin
               m0_sh_r <= {1'b1, m0_sh_r[7:1]};
            end
            if (m0_bit_r == M0_LAST_BIT) begin
               m0_act_r <= 1'b0;
            end
         end else begin
            m0_cnt_r <= m0_cnt_r + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Asynchronous transmitter
   // ----------------------------------------------------------------------
   assign atx_end = atx_act_r && tx_tick && (atx_sub_r == SUB_LAST) &&
                    (atx_bit_r == ((mode == MODE_ASYNC10) ? ASYNC_LAST_10 : ASYNC_LAST_11));

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         atx_act_r <= 1'b0;
         atx_sub_r <= 4'h0;
         atx_bit_r <= 4'h0;
         atx_sh_r  <= 11'h7ff;
      end else if (buf_wr && mode != MODE_SYNC8) begin
         atx_act_r <= 1'b1;
         atx_sub_r <= 4'h0;
         atx_bit_r <= 4'h0;
         if (mode == MODE_ASYNC10) begin
            atx_sh_r <= {2'h3, reg_wdata, 1'b0};
         end else begin
            atx_sh_r <= {1'b1, ctl_r[BIT_TX_NINTH], reg_wdata, 1'b0};
         end
      end else if (atx_act_r && tx_tick) begin
         atx_sub_r <= atx_sub_r + 4'h1;
         if (atx_sub_r == SUB_LAST) begin
            atx_sh_r  <= {1'b1, atx_sh_r[10:1]};
            atx_bit_r <= atx_bit_r + 4'h1;
            if (atx_end) begin
               atx_act_r <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Asynchronous receiver
   // ----------------------------------------------------------------------
   assign arx_samp  = (arx_st_r == ARX_BITS) && rx_tick && (arx_sub_r == SUB_MID);
   assign arx_last  = arx_samp && (arx_bit_r == RX_LAST_IDX);
   assign frame_bit = rxd_f_r;
   // Mode 1 checks the stop bit, modes 2/3 the ninth bit; both arrive at index 8.
   assign rx_accept = !ctl_r[BIT_RX_DONE] && (!ctl_r[BIT_MP_CHECK] || frame_bit);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         arx_st_r  <= ARX_IDLE;
         arx_sub_r <= 4'h0;
         arx_bit_r <= 4'h0;
         arx_sh_r  <= 8'h00;
      end else begin
         case (arx_st_r)
            ARX_IDLE: begin
               arx_sub_r <= 4'h0;
               arx_bit_r <= 4'h0;
               if (mode != MODE_SYNC8 && ctl_r[BIT_RX_ENABLE]
                   && rxd_prev_r && !rxd_f_r) begin
                  arx_st_r <= ARX_START;
               end
            end
            ARX_START: begin
               if (rx_tick) begin
                  arx_sub_r <= arx_sub_r + 4'h1;
                  if (arx_sub_r == SUB_MID) begin
                     arx_st_r <= rxd_f_r ? ARX_IDLE : ARX_BITS;
                  end
               end
            end
            ARX_BITS: begin
               if (rx_tick) begin
                  arx_sub_r <= arx_sub_r + 4'h1;
               end
               if (arx_samp) begin
                  arx_bit_r <= arx_bit_r + 4'h1;
                  if (arx_last) begin
                     arx_st_r <= ARX_IDLE;
                  end else begin
                     arx_sh_r <= {rxd_f_r, arx_sh_r[7:1]};
                  end
               end
            end
            default: begin
               arx_st_r <= ARX_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Done events and receive buffer
   // ----------------------------------------------------------------------
   assign tx_done_set = (m0_end && !m0_rx_r) || atx_end;
   assign rx_done_set = (m0_end && m0_rx_r) || (arx_last && rx_accept);
   // The ninth field is left alone in mode 1 while the check is on.
   assign rb8_load    = arx_last && rx_accept &&
                        !(mode == MODE_ASYNC10 && ctl_r[BIT_MP_CHECK]);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_buf_r <= SERIAL_BUFFER_RST;
      end else if (m0_end && m0_rx_r) begin
         rx_buf_r <= m0_sh_r;
      end else if (arx_last && rx_accept) begin
         rx_buf_r <= arx_sh_r;
      end
   end

   // ----------------------------------------------------------------------
   // Serial control register
   // ----------------------------------------------------------------------
   // Hardware sets win over a software clear in the same cycle, so no event is lost.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctl_r <= SERIAL_CONTROL_RST;
      end else begin
         if (ctl_wr) begin
            ctl_r <= reg_wdata;
         end
         if (tx_done_set) begin
            ctl_r[BIT_TX_DONE] <= 1'b1;
         end
         if (rx_done_set) begin
            ctl_r[BIT_RX_DONE] <= 1'b1;
         end
         if (rb8_load) begin
            ctl_r[BIT_RX_NINTH] <= frame_bit;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register read port and outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd && reg_addr == ADDR_SERIAL_CONTROL) begin
         rdata_r <= ctl_r;
      end else if (reg_rd && reg_addr == ADDR_SERIAL_BUFFER) begin
         rdata_r <= rx_buf_r;
      end else begin
         rdata_r <= 8'h00;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= serial_irq_enable && (ctl_r[BIT_TX_DONE] || ctl_r[BIT_RX_DONE]);
      end
   end

   // In mode 0 the tx pin is the shift clock, low in the first half of each bit.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         txd_r      <= 1'b1;
         rxd_out_r  <= 1'b1;
         rxd_oe_n_r <= 1'b1;
      end else if (mode == MODE_SYNC8) begin
         txd_r      <= !(m0_act_r && m0_cnt_r < m0_samp);
         rxd_out_r  <= m0_sh_r[0];
         rxd_oe_n_r <= !(m0_act_r && !m0_rx_r);
      end else begin
         txd_r      <= atx_act_r ? atx_sh_r[0] : 1'b1;
         rxd_out_r  <= 1'b1;
         rxd_oe_n_r <= 1'b1;
      end
   end

   assign reg_rdata  = rdata_r;
   assign serial_irq = irq_r;
   assign txd_out    = txd_r;
   assign rxd_out    = rxd_out_r;
   assign rxd_oe_n   = rxd_oe_n_r;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_buf_starts_async: assert property (
      buf_wr && mode != MODE_SYNC8 |=> atx_act_r && atx_bit_r == 4'h0 && !atx_sh_r[0])
      else $error("buffer write did not start async transmit");
   a_buf_starts_sync: assert property (
      buf_wr && mode == MODE_SYNC8 |=> m0_act_r && !m0_rx_r)
      else $error("buffer write did not start mode 0 transmit");
   a_tx_done_hold: assert property (
      ctl_r[BIT_TX_DONE] && !ctl_wr |=> ctl_r[BIT_TX_DONE])
      else $error("transmit done cleared without software");
   a_rx_done_hold: assert property (
      ctl_r[BIT_RX_DONE] && !ctl_wr |=> ctl_r[BIT_RX_DONE])
      else $error("receive done cleared without software");
   a_tx_done_cause: assert property (
      !ctl_r[BIT_TX_DONE] ##1 ctl_r[BIT_TX_DONE] |->
         $past(atx_end) || $past(m0_end && !m0_rx_r) || $past(ctl_wr))
      else $error("transmit done set without a finished frame");
   a_mp_discard: assert property (
      arx_last && ctl_r[BIT_MP_CHECK] && !frame_bit && !ctl_r[BIT_RX_DONE] && !ctl_wr
         |=> !ctl_r[BIT_RX_DONE] && $stable(rx_buf_r))
      else $error("frame failing the check was accepted");
   a_ren_blocks_rx: assert property (
      arx_st_r == ARX_IDLE && !ctl_r[BIT_RX_ENABLE] |=> arx_st_r == ARX_IDLE)
      else $error("reception started while disabled");
   a_ren_kept: assert property (
      ctl_r[BIT_RX_ENABLE] && !ctl_wr |=> ctl_r[BIT_RX_ENABLE])
      else $error("receive enable cleared by hardware");
   a_irq_follows: assert property (
      serial_irq_enable && ctl_r[BIT_RX_DONE] |=> serial_irq)
      else $error("interrupt not raised for done flag");
   a_m0_period: assert property (
      m0_act_r && m0_cnt_r == 4'h0 && !buf_wr |-> ##1 m0_cnt_r == 4'h1)
      else $error("mode 0 divider did not advance");
   a_ninth_sent: assert property (
      buf_wr && mode[1] |=> atx_sh_r[9] == $past(ctl_r[BIT_TX_NINTH]))
      else $error("ninth transmit bit not loaded");

   c_async_rx: cover property (arx_last && rx_accept);
   c_sync_tx: cover property (m0_end && !m0_rx_r);
   c_sync_rx: cover property (m0_end && m0_rx_r);
   c_mode2_tx: cover property (atx_end && mode == MODE_FIXED11);

endmodule // fmsp_top

// ### hw/fmsp_pkg.sv
// Constants of the four-mode serial port: register map, field layout and rate dividers.
// Assumes one system clock that is the oscillator, at the rate given below.
package fmsp_pkg;

   localparam int unsigned CLK_PERIOD_NS = 100;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
   localparam logic [7:0] ADDR_SERIAL_BUFFER  = 8'h99;
   localparam logic [7:0] SERIAL_CONTROL_RST  = 8'h00;
   localparam logic [7:0] SERIAL_BUFFER_RST   = 8'h00;

   // ----------------------------------------------------------------------
   // Serial control fields
   // ----------------------------------------------------------------------
   localparam int BIT_MODE_HIGH  = 7;
   localparam int BIT_MODE_LOW   = 6;
   localparam int BIT_MP_CHECK   = 5;
   localparam int BIT_RX_ENABLE  = 4;
   localparam int BIT_TX_NINTH   = 3;
   localparam int BIT_RX_NINTH   = 2;
   localparam int BIT_TX_DONE    = 1;
   localparam int BIT_RX_DONE    = 0;

   localparam logic [1:0] MODE_SYNC8   = 2'h0;
   localparam logic [1:0] MODE_ASYNC10 = 2'h1;
   localparam logic [1:0] MODE_FIXED11 = 2'h2;
   localparam logic [1:0] MODE_TIMER11 = 2'h3;

   // ----------------------------------------------------------------------
   // Rate dividers
   // ----------------------------------------------------------------------
   localparam logic [3:0] M0_DIV_TWELVE  = 4'hc;
   localparam logic [3:0] M0_DIV_SIX     = 4'h6;
   localparam logic [3:0] M0_SAMPLE_TW   = 4'h6;
   localparam logic [3:0] M0_SAMPLE_SIX  = 4'h3;
   // Mode 2 sub-bit prescale: bit divisor (64, 32, 16) over sixteen sub-bit ticks.
   localparam logic [2:0] M2_PRE_64      = 3'h4;
   localparam logic [2:0] M2_PRE_32      = 3'h2;
   localparam logic [2:0] M2_PRE_16      = 3'h1;
   localparam logic [3:0] SUB_LAST       = 4'hf;
   localparam logic [3:0] SUB_MID        = 4'h7;
   localparam logic [3:0] ASYNC_LAST_10  = 4'h9;
   localparam logic [3:0] ASYNC_LAST_11  = 4'ha;
   localparam logic [3:0] RX_LAST_IDX    = 4'h8;
   localparam logic [2:0] M0_LAST_BIT    = 3'h7;

endpackage

// ### sim/fmsp_peer.sv
// Far-side serial device model: async frame sender and receiver, mode 0 slave.
// Assumes the bench resolves the data pin from the port enable and pin_drv.
`timescale 1ns/1ps

module fmsp_peer (
   input  wire logic core_clk,
   input  wire logic txd_out,
   input  wire logic line,
   output logic      pin_drv
);
   int stalls = 0;

   initial pin_drv = 1'b1;

   // ----------------------------------------------------------------
   // Line tasks
   // ----------------------------------------------------------------
   // Bounded wait for a tx pin level; a bound that runs out is counted.
   task automatic wait_txd(input logic lvl, output int cyc);
      cyc = 0;
      while (txd_out !== lvl && cyc < 1000) begin
         @(posedge core_clk);
         cyc++;
      end
      if (cyc >= 1000) stalls++;
   endtask

   // The line rests high after a frame, as a pull-up would leave it.
   task automatic send(input logic [10:0] frm, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         pin_drv <= frm[i];
         repeat (per) @(posedge core_clk);
      end
      pin_drv <= 1'b1;
   endtask

   // The start bit follows the prescaler's phase, so the first data bit, which must be
   // one with a zero after it, is the one whose width measures the bit period.
   task automatic recv(input int n, input int per, output logic [10:0] bits, output int width);
      int c;
      bits = '0;
      wait_txd(1'b0, c);
      wait_txd(1'b1, c);
      wait_txd(1'b0, width);
      bits[1] = (width > 0);
      repeat (per / 2) @(posedge core_clk);
      for (int i = 2; i < n; i++) begin
         bits[i] = txd_out;
         repeat (per) @(posedge core_clk);
      end
   endtask

   // The port owns the shift clock; data is set while it is low.
   task automatic sync_xfer(input logic [7:0] d, output logic [7:0] got, output int span);
      int c;
      span = 0;
      for (int i = 0; i < 8; i++) begin
         wait_txd(1'b0, c);
         pin_drv <= d[i];
         if (i > 0) span += c;
         wait_txd(1'b1, c);
         got[i] = line;
         if (i > 0) span += c;
      end
      pin_drv <= 1'b1;
   endtask

endmodule // fmsp_peer

// ### sim/tb_top.sv
// Self-checking bench of the four-mode serial port with a far-side model.
// Assumes a 10 MHz clock and timer overflow pulses every second clock.
`timescale 1ns/1ps

module tb_top;
   import fmsp_pkg::*;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [10:0] frm;
      logic [3:0]  n;
      logic [7:0]  ec;
      logic [7:0]  eb;
   } fmsp_row_t;

   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        baud_double = 1'b1;
   logic        twelve_clk = 1'b1;
   logic        tmr_ovf = 1'b0;
   logic        irq_en = 1'b1;
   logic [7:0]  reg_rdata;
   logic        rxd_in, rxd_out, rxd_oe_n, txd_out, serial_irq, pin_drv;
   logic [10:0] bits;
   logic [7:0]  got;
   int          low, span;
   int          mismatches = 0;
   int          checked = 0;

   // Rows: control, frame LSB first, bit count, expected control and buffer.
   fmsp_row_t rows [9] = '{
      '{8'h90, {2'h2, 8'ha5, 1'b0}, 4'hb, 8'h91, 8'ha5},
      '{8'hb0, {2'h2, 8'h5a, 1'b0}, 4'hb, 8'hb0, 8'ha5},
      '{8'hb0, {2'h3, 8'h5a, 1'b0}, 4'hb, 8'hb5, 8'h5a},
      '{8'h80, {2'h3, 8'h33, 1'b0}, 4'hb, 8'h80, 8'h5a},
      '{8'h50, {2'h1, 8'hc3, 1'b0}, 4'ha, 8'h55, 8'hc3},
      '{8'h70, {2'h0, 8'h0f, 1'b0}, 4'ha, 8'h70, 8'hc3},
      '{8'h50, {2'h0, 8'h0f, 1'b0}, 4'ha, 8'h51, 8'h0f},
      '{8'hf0, {2'h3, 8'h96, 1'b0}, 4'hb, 8'hf5, 8'h96},
      '{8'h10, {2'h3, 8'h44, 1'b0}, 4'hb, 8'h10, 8'h96}};

   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) tmr_ovf <= ~tmr_ovf;
   assign rxd_in = rxd_oe_n ? pin_drv : rxd_out;

   fmsp_top i_fmsp_top (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .baud_double(baud_double), .twelve_clock_operation(twelve_clk),
      .timer1_overflow(tmr_ovf), .timer2_overflow(tmr_ovf), .rx_use_timer2(1'b1),
      .tx_use_timer2(1'b0), .serial_irq_enable(irq_en), .rxd_in(rxd_in),
      .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd_out(txd_out), .serial_irq(serial_irq));

   fmsp_peer i_fmsp_peer (.core_clk(core_clk), .txd_out(txd_out), .line(rxd_in),
      .pin_drv(pin_drv));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [10:0] g, input logic [10:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 chk({3'h0, reg_rdata}, {3'h0, e});
   endtask

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rd(ADDR_SERIAL_CONTROL, 8'h00);
      rd(ADDR_SERIAL_BUFFER, 8'h00);
      rd(8'h9a, 8'h00);
      chk({9'h0, txd_out, rxd_oe_n}, 11'h3);
      // Every async row runs at 32 clocks a bit.
      foreach (rows[i]) begin
         wr(ADDR_SERIAL_CONTROL, rows[i].ctrl);
         i_fmsp_peer.send(rows[i].frm, int'(rows[i].n), 32);
         repeat (20) @(posedge core_clk);
         rd(ADDR_SERIAL_CONTROL, rows[i].ec);
         rd(ADDR_SERIAL_BUFFER, rows[i].eb);
      end
      for (int d = 0; d < 2; d++) begin
         @(posedge core_clk) baud_double <= d[0];
         wr(ADDR_SERIAL_CONTROL, 8'h88);
         fork
            wr(ADDR_SERIAL_BUFFER, 8'h3d);
            i_fmsp_peer.recv(11, d ? 32 : 64, bits, low);
         join
         chk(11'(low), d ? 11'h20 : 11'h40);
         chk(bits, {2'h3, 8'h3d, 1'b0});
         rd(ADDR_SERIAL_CONTROL, 8'h8a);
         chk({10'h0, serial_irq}, 11'h1);
      end
      repeat (50) @(posedge core_clk);
      rd(ADDR_SERIAL_CONTROL, 8'h8a);
      @(posedge core_clk) irq_en <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk({10'h0, serial_irq}, 11'h0);
      @(posedge core_clk) irq_en <= 1'b1;
      wr(ADDR_SERIAL_CONTROL, 8'h80);
      rd(ADDR_SERIAL_CONTROL, 8'h80);
      chk({10'h0, serial_irq}, 11'h0);
      wr(ADDR_SERIAL_CONTROL, 8'h50);
      fork
         wr(ADDR_SERIAL_BUFFER, 8'h81);
         i_fmsp_peer.recv(10, 32, bits, low);
         i_fmsp_peer.send({2'h1, 8'h7e, 1'b0}, 10, 32);
      join
      chk(bits, {2'h1, 8'h81, 1'b0});
      rd(ADDR_SERIAL_CONTROL, 8'h57);
      rd(ADDR_SERIAL_BUFFER, 8'h7e);
      for (int t = 1; t >= 0; t--) begin
         @(posedge core_clk) twelve_clk <= t[0];
         wr(ADDR_SERIAL_CONTROL, 8'h00);
         fork
            wr(ADDR_SERIAL_BUFFER, 8'ha6);
            i_fmsp_peer.sync_xfer(8'hff, got, span);
         join
         chk({3'h0, got}, 11'h0a6);
         chk(11'(span), t ? 11'h54 : 11'h2a);
         repeat (8) @(posedge core_clk);
         rd(ADDR_SERIAL_CONTROL, 8'h02);
      end
      @(posedge core_clk) twelve_clk <= 1'b1;
      wr(ADDR_SERIAL_CONTROL, 8'h00);
      fork
         wr(ADDR_SERIAL_CONTROL, 8'h10);
         i_fmsp_peer.sync_xfer(8'h5c, got, span);
      join
      repeat (20) @(posedge core_clk);
      rd(ADDR_SERIAL_BUFFER, 8'h5c);
      rd(ADDR_SERIAL_CONTROL, 8'h11);
      @(posedge core_clk) rst <= 1'b1;
      @(posedge core_clk) rst <= 1'b0;
      rd(ADDR_SERIAL_BUFFER, 8'h00);
      rd(ADDR_SERIAL_CONTROL, 8'h00);
      chk({9'h0, txd_out, rxd_oe_n}, 11'h3);
      chk(11'(i_fmsp_peer.stalls), 11'h0);
      end_sim();
   end

endmodule // tb_top
